/* qsm_device.sv */
// Memory device end: instruction decoder, config registers and array
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Chip select low frames exactly one instruction
// - First item is 8-bit command, rising edge
// - Command alone or followed by address
// - Address is 24 bits, after command
// - Write data sampled on rising edges
// - Read data driven on falling edges
// - Write-enable instruction sets the latch
// - Write instruction end clears the latch
// - Write-disable instruction clears the latch
// - SRAM or back-to-back mode keeps latch after memory writes
// - Continuous write follows config two bit 4
// - Latency cycles between address and read data
// - Mode byte A enters, F leaves continuous
// - Continuous mode skips command, repeats operation
// - Wrap reads confined to aligned window
// - Address auto-increments per data unit
// - All fields shifted most significant first
// - Lane counts per phase: 1-1-1 or 1-4-4
// - Latency count from config two bits 3:0
// - Config one bits 1:0 waive write-enable for memory writes
module qsm_device #(
  parameter int MEM_AW = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Serial link
  qsm_link.dev link,
  // Status
  output logic write_enable_latch,
  output logic continuous_mode,
  output logic frame_active
);
  if (MEM_AW < 4 || MEM_AW > 24) begin : g_chk
    $error("MEM_AW must lie in 4..24");
  end

  typedef enum logic [6:0] {
    ST_CMD = 7'b000_0001,
    ST_ADDR = 7'b000_0010,
    ST_MODE = 7'b000_0100,
    ST_LAT = 7'b000_1000,
    ST_WDATA = 7'b001_0000,
    ST_RDATA = 7'b010_0000,
    ST_DONE = 7'b100_0000
  } dev_st_e;

  typedef struct packed {
    dev_st_e st;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] sh;
    logic [4:0] cnt;
    logic quad;
    logic wrote;
    logic cont;
    logic [7:0] cont_cmd;
    logic wel;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic sclk_d;
    logic [3:0] dout;
    logic [3:0] doe;
  } dev_s;

  dev_s q;
  dev_s nxt_q;
  logic [7:0] mem [2**MEM_AW];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [5:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic f_quad(input logic [7:0] op);
    return op == qsm_pkg::OP_QUAD_READ || op == qsm_pkg::OP_QUAD_WRITE;
  endfunction

  function automatic logic f_fast(input logic [7:0] op);
    return op == qsm_pkg::OP_FAST_READ || op == qsm_pkg::OP_QUAD_READ;
  endfunction

  function automatic logic f_rd(input logic [7:0] op);
    return op == qsm_pkg::OP_READ || f_fast(op) || op == qsm_pkg::OP_READ_REG;
  endfunction

  function automatic logic f_wr(input logic [7:0] op);
    return op == qsm_pkg::OP_WRITE || op == qsm_pkg::OP_QUAD_WRITE;
  endfunction

  function automatic logic f_reg(input logic [7:0] op);
    return op == qsm_pkg::OP_WRITE_REG || op == qsm_pkg::OP_READ_REG;
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
                                            input logic [2:0] sel);
    logic [23:0] m;
    m = 24'((24'h00_0010 << (sel - 3'h1)) - 24'h00_0001);
    if (!wrap || sel == 3'h0 || sel > 3'h5) begin
      return a + 24'h00_0001;
    end
    return (a & ~m) | ((a + 24'h00_0001) & m);
  endfunction

  function automatic logic [7:0] reg_rd(input dev_s s);
    case (s.addr[2:0])
      qsm_pkg::REG_CFG1: reg_rd = s.cfg1;
      qsm_pkg::REG_CFG2: reg_rd = s.cfg2;
      qsm_pkg::REG_CFG3: reg_rd = s.cfg3;
      qsm_pkg::REG_CFG4: reg_rd = s.cfg4;
      qsm_pkg::REG_STATUS: reg_rd = 8'(s.wel) << qsm_pkg::STATUS_WEL_BIT;
      default: reg_rd = 8'h00;
    endcase
  endfunction

  // data phase entry, latency only for fast reads
  function automatic dev_s to_data(input dev_s s);
    dev_s r;
    r = s;
    if (f_rd(s.cmd)) begin
      if (f_fast(s.cmd) && s.cfg2[3:0] != 4'h0) begin
        r.st = ST_LAT;
        r.cnt = {1'b0, s.cfg2[3:0]};
      end else begin
        r.st = ST_RDATA;
        r.cnt = 5'h00;
      end
    end else begin
      r.st = ST_WDATA;
      r.cnt = s.quad ? qsm_pkg::CNT_BYTE4 : qsm_pkg::CNT_BYTE1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  sync2 #(.W(6), .RST_VAL(6'b10_0000)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d({link.cs_n, link.sclk, link.io}),
    .q(pins_s)
  );

  assign cs_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];
  assign rise = sclk_s & ~q.sclk_d;
  assign fall = ~sclk_s & q.sclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] din;
    logic [7:0] b;
    logic ok;
    nxt_q = q;
    b = 8'h00;
    ok = 1'b0;
    mem_we = 1'b0;
    mem_wa = q.addr[MEM_AW-1:0];
    mem_wd = 8'h00;
    nxt_q.sclk_d = sclk_s;
    din = q.quad ? {q.sh[3:0], io_s} : {q.sh[6:0], io_s[0]};
    if (cs_s) begin
      if (q.wrote && (f_reg(q.cmd) || !(q.cfg4[qsm_pkg::CFG4_SRAM_BIT]
          || q.cfg4[qsm_pkg::CFG4_B2B_BIT]))) begin
        nxt_q.wel = 1'b0;
      end
      nxt_q.wrote = 1'b0;
      nxt_q.doe = 4'h0;
      nxt_q.sh = 8'h00;
      if (q.cont) begin
        nxt_q.st = ST_ADDR;
        nxt_q.cmd = q.cont_cmd;
        nxt_q.quad = f_quad(q.cont_cmd);
        nxt_q.cnt = f_quad(q.cont_cmd) ? qsm_pkg::CNT_ADDR4 : qsm_pkg::CNT_ADDR1;
      end else begin
        nxt_q.st = ST_CMD;
        nxt_q.quad = 1'b0;
        nxt_q.cnt = qsm_pkg::CNT_CMD;
      end
    end else if (rise) begin
      case (q.st)
        ST_CMD: begin
          nxt_q.sh = din;
          nxt_q.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h01) begin
            nxt_q.cmd = din;
            nxt_q.sh = 8'h00;
            nxt_q.st = ST_DONE;
            if (din == qsm_pkg::OP_WRITE_ENABLE) begin
              nxt_q.wel = 1'b1;
            end else if (din == qsm_pkg::OP_WRITE_DISABLE) begin
              nxt_q.wel = 1'b0;
            end else if (f_rd(din) || f_wr(din) || f_reg(din)) begin
              nxt_q.st = ST_ADDR;
              nxt_q.quad = f_quad(din);
              nxt_q.cnt = f_quad(din) ? qsm_pkg::CNT_ADDR4 : qsm_pkg::CNT_ADDR1;
            end
          end
        end
        ST_ADDR: begin
          nxt_q.addr = q.quad ? {q.addr[19:0], io_s} : {q.addr[22:0], io_s[0]};
          nxt_q.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h01) begin
            if (q.cmd == qsm_pkg::OP_QUAD_WRITE) begin
              nxt_q.cont = q.cfg2[qsm_pkg::CFG2_CONT_WR_BIT];
              nxt_q.cont_cmd = q.cmd;
            end
            if (f_fast(q.cmd)) begin
              nxt_q.st = ST_MODE;
              nxt_q.cnt = q.quad ? qsm_pkg::CNT_BYTE4 : qsm_pkg::CNT_BYTE1;
            end else begin
              nxt_q = to_data(nxt_q);
            end
          end
        end
        ST_MODE: begin
          nxt_q.sh = din;
          nxt_q.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h01) begin
            if (din[7:4] == qsm_pkg::CONT_ENTER) begin
              nxt_q.cont = 1'b1;
              nxt_q.cont_cmd = q.cmd;
            end else if (din[7:4] == qsm_pkg::CONT_EXIT) begin
              nxt_q.cont = 1'b0;
            end
            nxt_q = to_data(nxt_q);
          end
        end
        ST_LAT: begin
          nxt_q.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h01) begin
            nxt_q.st = ST_RDATA;
            nxt_q.cnt = 5'h00;
          end
        end
        ST_WDATA: begin
          nxt_q.sh = din;
          nxt_q.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h01) begin
            nxt_q.cnt = q.quad ? qsm_pkg::CNT_BYTE4 : qsm_pkg::CNT_BYTE1;
            nxt_q.addr = q.addr + 24'h00_0001;
            // config one may waive the latch
            ok = q.wel || (!f_reg(q.cmd) && q.cfg1[1:0] != 2'b00);
            nxt_q.wrote = ok;
            if (ok && f_reg(q.cmd)) begin
              case (q.addr[2:0])
                qsm_pkg::REG_CFG1: nxt_q.cfg1 = din;
                qsm_pkg::REG_CFG2: nxt_q.cfg2 = din;
                qsm_pkg::REG_CFG3: nxt_q.cfg3 = din;
                qsm_pkg::REG_CFG4: nxt_q.cfg4 = din;
                default: nxt_q.cfg1 = q.cfg1;
              endcase
            end else if (ok) begin
              mem_we = 1'b1;
              mem_wd = din;
            end
          end
        end
        default: nxt_q.st = q.st;
      endcase
    end else if (fall && q.st == ST_RDATA) begin
      // read data change on falling edges
      if (q.cnt == 5'h00) begin
        b = f_reg(q.cmd) ? reg_rd(q) : mem[q.addr[MEM_AW-1:0]];
        nxt_q.addr = next_addr(q.addr, !f_reg(q.cmd), q.cfg3[2:0]);
        nxt_q.cnt = q.quad ? 5'h01 : 5'h07;
      end else begin
        b = q.sh;
        nxt_q.cnt = q.cnt - 5'h01;
      end
      nxt_q.sh = q.quad ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
      nxt_q.dout = q.quad ? b[7:4] : {2'b00, b[7], 1'b0};
      nxt_q.doe = q.quad ? 4'hF : 4'h2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{st: ST_CMD, cnt: qsm_pkg::CNT_CMD, cfg1: qsm_pkg::CFG_RST,
             cfg2: qsm_pkg::CFG_RST, cfg3: qsm_pkg::CFG_RST,
             cfg4: qsm_pkg::CFG_RST, default: '0};
    end else begin
      q <= nxt_q;
    end
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link.d_o = q.dout;
  assign link.d_oe = q.doe;
  assign write_enable_latch = q.wel;
  assign continuous_mode = q.cont;
  assign frame_active = ~cs_s;
endmodule

/* qsm_host.sv */
// Host controller end: register-driven instruction sequencer
`timescale 1ns/1ps
module qsm_host #(
  parameter int HALF = qsm_pkg::HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Serial link
  qsm_link.host link
);
  // Device answer crosses two synchronisers; shorter halves miss it
  if (HALF < 8 || HALF > 255) begin : g_chk
    $error("HALF must lie in 8..255");
  end

  typedef enum logic [6:0] {
    H_IDLE = 7'b000_0001,
    H_CMD = 7'b000_0010,
    H_ADDR = 7'b000_0100,
    H_MODE = 7'b000_1000,
    H_LAT = 7'b001_0000,
    H_DATA = 7'b010_0000,
    H_END = 7'b100_0000
  } hst_e;

  typedef struct packed {
    hst_e st;
    logic [15:0] ctl;
    logic [23:0] addr;
    logic [11:0] mode;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [3:0] o;
    logic [3:0] oe;
    logic [31:0] rd_out;
  } hst_s;

  hst_s q;
  hst_s nxt_q;
  logic [3:0] io_s;

  sync2 #(.W(4), .RST_VAL(4'h0)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d(link.io),
    .q(io_s)
  );

  // First non-empty phase after cur
  function automatic hst_e next_ph(input hst_s s, input hst_e cur);
    if (cur < H_ADDR && s.ctl[qsm_pkg::HC_ADDR]) return H_ADDR;
    if (cur < H_MODE && s.ctl[qsm_pkg::HC_MODE]) return H_MODE;
    if (cur < H_LAT && s.mode[11:8] != 4'h0) return H_LAT;
    if (cur < H_DATA && s.ctl[15:13] != 3'h0) return H_DATA;
    return H_END;
  endfunction

  function automatic hst_s load(input hst_s s, input hst_e p);
    hst_s r;
    logic l4;
    r = s;
    l4 = s.ctl[qsm_pkg::HC_QUAD];
    r.st = p;
    r.sh = 32'h0000_0000;
    r.cnt = 6'h01;
    case (p)
      H_CMD: begin
        r.sh = {s.ctl[7:0], 24'h00_0000};
        r.cnt = 6'(qsm_pkg::CNT_CMD);
      end
      H_ADDR: begin
        r.sh = {s.addr, 8'h00};
        r.cnt = 6'(l4 ? qsm_pkg::CNT_ADDR4 : qsm_pkg::CNT_ADDR1);
      end
      H_MODE: begin
        r.sh = {s.mode[7:0], 24'h00_0000};
        r.cnt = 6'(l4 ? qsm_pkg::CNT_BYTE4 : qsm_pkg::CNT_BYTE1);
      end
      H_LAT: r.cnt = {2'b00, s.mode[11:8]};
      H_DATA: begin
        r.sh = s.wdata;
        r.cnt = l4 ? {2'b00, s.ctl[15:13], 1'b0} : {s.ctl[15:13], 3'b000};
      end
      default: r.cnt = 6'h01;
    endcase
    return r;
  endfunction

  // Drive the next bits while the clock is low
  function automatic hst_s present(input hst_s s);
    hst_s r;
    logic l4;
    r = s;
    l4 = s.ctl[qsm_pkg::HC_QUAD] && s.st != H_CMD;
    if (s.st == H_CMD || s.st == H_ADDR || s.st == H_MODE
        || (s.st == H_DATA && !s.ctl[qsm_pkg::HC_READ])) begin
      r.o = l4 ? s.sh[31:28] : {3'b000, s.sh[31]};
      r.oe = l4 ? 4'hF : 4'h1;
      r.sh = l4 ? {s.sh[27:0], 4'h0} : {s.sh[30:0], 1'b0};
    end else begin
      r.oe = 4'h0;
    end
    return r;
  endfunction

  always_comb begin
    logic tick;
    nxt_q = q;
    tick = 1'b0;
    // Register writes
    if (reg_we) begin
      case (reg_addr)
        qsm_pkg::HREG_CMD: begin
          if (q.st == H_IDLE) begin
            nxt_q.ctl = reg_wdata[15:0];
          end
        end
        qsm_pkg::HREG_ADDR: nxt_q.addr = reg_wdata[23:0];
        qsm_pkg::HREG_MODE: nxt_q.mode = reg_wdata[11:0];
        qsm_pkg::HREG_WDATA: nxt_q.wdata = reg_wdata;
        default: nxt_q.ctl = q.ctl;
      endcase
    end
    // Register reads, answered next cycle
    nxt_q.rd_out = 32'h0000_0000;
    if (reg_re) begin
      case (reg_addr)
        qsm_pkg::HREG_CMD: nxt_q.rd_out = {16'h0000, q.ctl};
        qsm_pkg::HREG_ADDR: nxt_q.rd_out = {8'h00, q.addr};
        qsm_pkg::HREG_MODE: nxt_q.rd_out = {20'h0_0000, q.mode};
        qsm_pkg::HREG_WDATA: nxt_q.rd_out = q.wdata;
        qsm_pkg::HREG_RDATA: nxt_q.rd_out = q.rdata;
        qsm_pkg::HREG_STATUS: nxt_q.rd_out = {31'h0000_0000, q.st != H_IDLE};
        default: nxt_q.rd_out = 32'h0000_0000;
      endcase
    end
    if (q.st == H_IDLE) begin
      nxt_q.div = 8'h00;
      if (reg_we && reg_addr == qsm_pkg::HREG_CMD && reg_wdata[qsm_pkg::HC_GO]) begin
        nxt_q.cs_n = 1'b0;
        nxt_q.rdata = 32'h0000_0000;
        nxt_q = present(load(nxt_q, reg_wdata[qsm_pkg::HC_SKIP] ?
                             next_ph(nxt_q, H_CMD) : H_CMD));
      end
    end else begin
      tick = q.div == 8'(HALF - 1);
      nxt_q.div = tick ? 8'h00 : q.div + 8'h01;
    end
    if (tick && q.st == H_END) begin
      nxt_q.sclk = 1'b0;
      nxt_q.oe = 4'h0;
      if (!q.sclk) begin
        nxt_q.cs_n = 1'b1;
        nxt_q.st = H_IDLE;
      end
    end else if (tick && !q.sclk) begin
      nxt_q.sclk = 1'b1;
      if (q.st == H_DATA && q.ctl[qsm_pkg::HC_READ]) begin
        nxt_q.rdata = q.ctl[qsm_pkg::HC_QUAD] ? {q.rdata[27:0], io_s}
                                               : {q.rdata[30:0], io_s[1]};
      end
      nxt_q.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        nxt_q = load(nxt_q, next_ph(q, q.st));
      end
    end else if (tick) begin
      nxt_q.sclk = 1'b0;
      nxt_q = present(nxt_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '{st: H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      q <= nxt_q;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.h_o = q.o;
  assign link.h_oe = q.oe;
  assign reg_rdata = q.rd_out;
endmodule

/* qsm_link.sv */
// Serial link between host controller and memory device
`timescale 1ns/1ps
interface qsm_link;
  logic sclk;
  logic cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] io;

  // Pull-up level when nobody drives a lane
  assign io = (h_oe & h_o) | (d_oe & d_o) | ~(h_oe | d_oe);

  modport host (output sclk, output cs_n, output h_o, output h_oe, input io);
  modport dev (input sclk, input cs_n, input io, output d_o, output d_oe);
endinterface

/* qsm_link_chk.sv */
// Link checker for the quad serial memory instruction port
`timescale 1ns/1ps
module qsm_link_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("link clock not low outside a frame");
  chk_frame_lead_in: assert property ($fell(cs_n) |-> !sclk[*7] ##[1:2] sclk)
    else $error("first clock rise not one half period after select");
  chk_high_half_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("clock high phase length wrong");
  chk_low_half_len: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("clock low phase too short");
  chk_host_hold_high: assert property (sclk && $past(sclk) |-> $stable(h_o & h_oe))
    else $error("host lanes changed while clock high");
  chk_dev_launch_low: assert property ($changed(d_o & d_oe) |-> !sclk)
    else $error("device lanes changed while clock high");
  chk_dev_lane_set: assert property (d_oe inside {4'h0, 4'h2, 4'hF})
    else $error("device drives an illegal lane set");
  chk_dev_release: assert property (cs_n[*5] |-> d_oe == 4'h0)
    else $error("device still drives lanes after deselect");
  chk_idle_lanes_high: assert property (cs_n[*5] |-> io == 4'hF)
    else $error("a lane is still driven after deselect");
  chk_no_contention: assert property ((h_oe & d_oe) == 4'h0)
    else $error("host and device drive one lane");
endmodule

/* qsm_pkg.sv */
// Shared constants for the quad serial memory instruction port
package qsm_pkg;
  // Instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_WRITE = 8'hD2;
  localparam logic [7:0] OP_WRITE_REG = 8'h71;
  localparam logic [7:0] OP_READ_REG = 8'h65;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // Mode byte upper nibbles
  localparam logic [3:0] CONT_ENTER = 4'hA;
  localparam logic [3:0] CONT_EXIT = 4'hF;
  // Clock counts per phase (one lane / four lanes)
  localparam logic [4:0] CNT_CMD = 5'h08;
  localparam logic [4:0] CNT_ADDR1 = 5'h18;
  localparam logic [4:0] CNT_ADDR4 = 5'h06;
  localparam logic [4:0] CNT_BYTE1 = 5'h08;
  localparam logic [4:0] CNT_BYTE4 = 5'h02;
  // Device register indexes
  localparam logic [2:0] REG_CFG1 = 3'h0;
  localparam logic [2:0] REG_CFG2 = 3'h1;
  localparam logic [2:0] REG_CFG3 = 3'h2;
  localparam logic [2:0] REG_CFG4 = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  // Device register fields
  localparam int CFG2_CONT_WR_BIT = 4;
  localparam int CFG4_SRAM_BIT = 0;
  localparam int CFG4_B2B_BIT = 1;
  localparam int STATUS_WEL_BIT = 1;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Host register offsets
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_ADDR = 8'h04;
  localparam logic [7:0] HREG_MODE = 8'h08;
  localparam logic [7:0] HREG_WDATA = 8'h0C;
  localparam logic [7:0] HREG_RDATA = 8'h10;
  localparam logic [7:0] HREG_STATUS = 8'h14;
  // Host command register fields
  localparam int HC_SKIP = 8;
  localparam int HC_QUAD = 9;
  localparam int HC_ADDR = 10;
  localparam int HC_MODE = 11;
  localparam int HC_READ = 12;
  localparam int HC_LEN = 13;
  localparam int HC_GO = 16;
  // Link clock half period in core clocks
  localparam int HALF_CYC = 8;
endpackage

/* quad_serial_memory_instruction_port_tb_top.sv */
// Testbench: host register port in, device status and link checked
`timescale 1ns/1ps
`define CHECK(act, exp) begin \
  cmp_count++; \
  if ((act) !== (exp)) begin \
    bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, act, exp); \
  end \
end
module quad_serial_memory_instruction_port_tb_top;
  // Flag sets {read, mode, addr, quad, skip}
  localparam logic [4:0] F_WA = 5'h04;
  localparam logic [4:0] F_RA = 5'h14;
  localparam logic [4:0] F_FR = 5'h1C;
  localparam logic [4:0] F_QR = 5'h1E;
  localparam logic [4:0] F_QS = 5'h1F;
  localparam logic [4:0] F_WQ = 5'h06;
  localparam logic [4:0] F_WS = 5'h07;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic wel;
  logic cont;
  logic fact;
  logic [31:0] d;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  qsm_link link();
  qsm_host #(.HALF(8)) qsm_host_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .link(link));
  qsm_device #(.MEM_AW(10)) qsm_device_inst (.core_clk(core_clk), .srst(srst), .link(link),
    .write_enable_latch(wel), .continuous_mode(cont), .frame_active(fact));
  qsm_link_chk qsm_link_chk_inst (.core_clk(core_clk), .srst(srst), .sclk(link.sclk),
    .cs_n(link.cs_n), .h_o(link.h_o), .h_oe(link.h_oe), .d_o(link.d_o), .d_oe(link.d_oe),
    .io(link.io));

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Longest run is well under this; a hung busy flag ends here
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    reg_we <= w;
    reg_re <= r;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    bus(1'b0, 1'b0, a, 32'h0000_0000);
    v = reg_rdata;
  endtask

  function automatic logic [31:0] cw(input logic [7:0] op, input logic [4:0] fl,
                                     input logic [2:0] n);
    cw = {15'h0000, 1'b1, n, fl, op};
  endfunction

  task automatic op(input logic [31:0] c, input logic [23:0] a, input logic [11:0] m,
                    input logic [31:0] wd, output logic [31:0] v);
    int n;
    n = 0;
    bus(1'b1, 1'b0, qsm_pkg::HREG_ADDR, {8'h00, a});
    bus(1'b1, 1'b0, qsm_pkg::HREG_MODE, {20'h0_0000, m});
    bus(1'b1, 1'b0, qsm_pkg::HREG_WDATA, wd);
    bus(1'b1, 1'b0, qsm_pkg::HREG_CMD, c);
    do begin
      rd(qsm_pkg::HREG_STATUS, v);
      n++;
    end while (v[0] !== 1'b0 && n < 5000);
    if (v[0] !== 1'b0) begin
      bad_count++;
      $display("[ERR] %0t busy never cleared", $time);
    end
    rd(qsm_pkg::HREG_RDATA, v);
    // Device sees chip select through a synchroniser, so let it settle
    repeat (8) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
  endtask

  task automatic wen;
    op(cw(qsm_pkg::OP_WRITE_ENABLE, 5'h00, 3'h0), 24'h00_0000, 12'h000, 32'h0000_0000, d);
  endtask

  task automatic wreg(input logic [2:0] i, input logic [7:0] v);
    wen();
    op(cw(qsm_pkg::OP_WRITE_REG, F_WA, 3'h1), {21'h00_0000, i}, 12'h000, {v, 24'h00_0000}, d);
  endtask

  task automatic wr(input logic [23:0] a, input logic [2:0] n, input logic [31:0] v);
    op(cw(qsm_pkg::OP_WRITE, F_WA, n), a, 12'h000, v, d);
  endtask

  task automatic rdm(input logic [23:0] a, input logic [2:0] n);
    op(cw(qsm_pkg::OP_READ, F_RA, n), a, 12'h000, 32'h0000_0000, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    op(cw(qsm_pkg::OP_READ_REG, F_RA, 3'h1), 24'h00_0004, 12'h000, 32'h0000_0000, d);
    `CHECK(d[1], 1'b0)
    `CHECK(fact, 1'b0)
    wen();
    `CHECK(wel, 1'b1)
    op(cw(qsm_pkg::OP_READ_REG, F_RA, 3'h1), 24'h00_0004, 12'h000, 32'h0000_0000, d);
    `CHECK(d[1], 1'b1)
    wr(24'h00_0010, 3'h1, 32'hA500_0000);
    `CHECK(wel, 1'b0)
    rdm(24'h00_0010, 3'h1);
    `CHECK(d[7:0], 8'hA5)
    wr(24'h00_0010, 3'h1, 32'h5A00_0000);
    rdm(24'h00_0010, 3'h1);
    `CHECK(d[7:0], 8'hA5)
    wen();
    op(cw(qsm_pkg::OP_WRITE_DISABLE, 5'h00, 3'h0), 24'h00_0000, 12'h000, 32'h0000_0000, d);
    `CHECK(wel, 1'b0)
    wen();
    wr(24'h00_0020, 3'h4, 32'h1122_3344);
    rdm(24'h00_0020, 3'h4);
    `CHECK(d, 32'h1122_3344)
    for (int m = 1; m < 3; m++) begin
      wreg(qsm_pkg::REG_CFG4, m[7:0]);
      `CHECK(wel, 1'b0)
      wen();
      wr(24'h00_0030, 3'h1, 32'h3C00_0000);
      `CHECK(wel, 1'b1)
    end
    wreg(qsm_pkg::REG_CFG4, 8'h00);
    wreg(qsm_pkg::REG_CFG2, 8'h04);
    op(cw(qsm_pkg::OP_FAST_READ, F_FR, 3'h2), 24'h00_0020, 12'h400, 32'h0000_0000, d);
    `CHECK(d[15:0], 16'h1122)
    `CHECK(cont, 1'b0)
    op(cw(qsm_pkg::OP_QUAD_READ, F_QR, 3'h2), 24'h00_0020, 12'h4A0, 32'h0000_0000, d);
    `CHECK(d[15:0], 16'h1122)
    `CHECK(cont, 1'b1)
    op(cw(qsm_pkg::OP_QUAD_READ, F_QS, 3'h2), 24'h00_0022, 12'h4F0, 32'h0000_0000, d);
    `CHECK(d[15:0], 16'h3344)
    `CHECK(cont, 1'b0)
    wen();
    wr(24'h00_002E, 3'h2, 32'hCAFE_0000);
    wreg(qsm_pkg::REG_CFG3, 8'h01);
    rdm(24'h00_002E, 3'h4);
    `CHECK(d, 32'hCAFE_1122)
    wreg(qsm_pkg::REG_CFG1, 8'h01);
    wr(24'h00_0040, 3'h1, 32'h7700_0000);
    rdm(24'h00_0040, 3'h1);
    `CHECK(d[7:0], 8'h77)
    // Last: continuous write repeats in a frame without command and stays on
    wreg(qsm_pkg::REG_CFG2, 8'h14);
    op(cw(qsm_pkg::OP_QUAD_WRITE, F_WQ, 3'h2), 24'h00_0050, 12'h000, 32'hBEEF_0000, d);
    `CHECK(cont, 1'b1)
    op(cw(qsm_pkg::OP_QUAD_WRITE, F_WS, 3'h1), 24'h00_0052, 12'h000, 32'h5500_0000, d);
    `CHECK(qsm_device_inst.mem[82], 8'h55)
    `CHECK(cont, 1'b1)
    give_verdict();
  end
endmodule

/* sync2.sv */
// Two-flop synchroniser for pins from another clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
